// File: rtl/clock_output_divider.sv
// Clock-output divider that toggles every divide-select bus cycles
`timescale 1ns/1ps
`include "sysconfig_defs.svh"
module clock_output_divider
(
    input  wire logic                       clk_i,      // Bus clock
    input  wire logic                       reset_i,    // Sync reset
    input  wire logic                       enable_i,   // Pin enable
    input  wire logic [`CLKOUT_DIV_W-1:0]   divide_i,   // Divide select
    output logic                            clk_out_o,  // Pin level
    output logic                            clk_oe_o    // Pin drive enable
);
    logic [`CLKOUT_DIV_W-1:0] count_reg;
    logic                     level_reg;

    // Half period of divide cycles gives bus/(2*divide)
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !enable_i || divide_i == '0)
        begin
            count_reg <= '0;
            level_reg <= 1'b0;
        end
        else if (count_reg >= divide_i - 1'b1)
        begin
            count_reg <= '0;
            level_reg <= ~level_reg;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            clk_oe_o <= 1'b0;
        else
            clk_oe_o <= enable_i;
    end

    assign clk_out_o = level_reg;
endmodule

// File: rtl/sysconfig_defs.svh
// Offsets, field positions, reset values and timing constants for the system configuration block
`ifndef SYSCONFIG_DEFS_SVH
`define SYSCONFIG_DEFS_SVH

`define ADDR_SYSTEM_OPTIONS      4'h0
`define ADDR_CLOCK_OUTPUT_CTRL   4'h1
`define ADDR_PART_IDENTITY_HIGH  4'h2
`define ADDR_PART_IDENTITY_LOW   4'h3
`define ADDR_WAKEUP_STATUS_CTRL  4'h4

`define OPT_WDOG_EN_BIT     7
`define OPT_WDOG_LONG_BIT   6
`define OPT_STOP_ALLOW_BIT  5
`define OPT_RESET_VALUE     8'hC0
`define OPT_IMPL_MASK       8'hE3

`define CLKOUT_EN_BIT       7
`define CLKOUT_DIV_HI       2
`define CLKOUT_DIV_W        3

`define WAKE_FLAG_BIT       7
`define WAKE_ACK_BIT        6
`define WAKE_CLKSEL_BIT     5
`define WAKE_IRQ_EN_BIT     4
`define WAKE_DELAY_HI       2
`define WAKE_DELAY_W        3

// Arbitrary part number, not a real device code
`define PART_ID_VALUE       12'h5A5
`define PART_ID_HIGH_SHIFT  8
`define ID_HIGH_RESERVED    4'h0

`define INT_OSC_PERIOD_NS   1000000
`define CLK_PERIOD_NS       4
`define INT_TICK_CYCLES     (`INT_OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define WAKE_CNT_W          26

// Wakeup periods in internal 1 ms ticks, delay codes 1 to 7
`define WAKE_INT_TICKS_1    16'h0008
`define WAKE_INT_TICKS_2    16'h0020
`define WAKE_INT_TICKS_3    16'h0040
`define WAKE_INT_TICKS_4    16'h0080
`define WAKE_INT_TICKS_5    16'h0100
`define WAKE_INT_TICKS_6    16'h0200
`define WAKE_INT_TICKS_7    16'h0400

// Wakeup periods in external clock edges, delay codes 1 to 7
`define WAKE_EXT_EDGES_1    16'h0100
`define WAKE_EXT_EDGES_2    16'h0400
`define WAKE_EXT_EDGES_3    16'h0800
`define WAKE_EXT_EDGES_4    16'h1000
`define WAKE_EXT_EDGES_5    16'h2000
`define WAKE_EXT_EDGES_6    16'h4000
`define WAKE_EXT_EDGES_7    16'h8000

`endif

// File: rtl/sysconfig_pkg.sv
// Types shared by the system configuration block
package sysconfig_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] delay_sel_t;
endpackage

// File: rtl/system_config_and_periodic_wakeup.sv
// System configuration register bank with clock output and periodic wakeup
//
// Function
// - Options readable; bits 4,3,2 read zero
// - Options accept only first write after reset
// - Bit 7 watchdog enable, resets to one
// - Bit 6 watchdog long timeout, resets one
// - Bit 5 stop allow, resets to zero
// - Stop while disallowed forces illegal-opcode reset
// - Pin enable drives clock out on pin
// - Zero divide select drives pin low
// - Identity pair read-only, high nibble reserved
// - Identity pair returns fixed 12-bit number
// - Wakeup register unimplemented bits read zero
// - Bit 7 flag set on wakeup timeout
// - Writing one to bit 6 clears flag
// - Bit 5 selects internal or external clock
// - Internal wakeup clock runs independently always
// - Bit 4 enables wakeup interrupt
// - Internal delay codes 8 ms to 1.024 s
// - External delay codes divide 256 to 32768
`timescale 1ns/1ps
`include "sysconfig_defs.svh"
module system_config_and_periodic_wakeup
(
    input  wire logic        clk_i,                   // Bus clock, 250 MHz
    input  wire logic        reset_i,                 // Sync reset, active high
    input  wire logic [3:0]  addr_i,                  // Register address
    input  wire logic [7:0]  wdata_i,                 // Write data
    input  wire logic        write_i,                 // Write strobe
    input  wire logic        read_i,                  // Read strobe
    output logic      [7:0]  rdata_o,                 // Read data, next cycle
    input  wire logic        ext_clk_i,               // External wakeup clock pin
    input  wire logic        stop_request_i,          // Stop instruction executed
    output logic             stop_enter_o,            // Enter stop mode pulse
    output logic             illegal_opcode_reset_o,  // Reset request pulse
    output logic             watchdog_enable_o,       // Watchdog enabled
    output logic             watchdog_long_timeout_o, // Long watchdog period
    output logic             port_c_bit2_pin_o,       // Clock output level
    output logic             port_c_bit2_pin_oe_o,    // Clock output drive enable
    output logic             periodic_wakeup_interrupt_o // Wakeup request level
);
    ////////////////////////////////////////////////////////////////////////////
    sysconfig_pkg::byte_t       system_options_reg;
    logic                       options_locked_reg;
    logic                       clock_output_pin_enable_reg;
    sysconfig_pkg::delay_sel_t  clock_output_divide_select_reg;
    logic                       wakeup_timeout_flag_reg;
    logic                       wakeup_clock_select_reg;
    logic                       wakeup_interrupt_enable_reg;
    sysconfig_pkg::delay_sel_t  wakeup_delay_select_reg;
    logic                       timeout;
    logic                       ack;
    sysconfig_pkg::byte_t       rdata_next;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
        return a == target;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Options: write-once, lock survives until reset
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            system_options_reg <= `OPT_RESET_VALUE;
            options_locked_reg <= 1'b0;
        end
        else if (write_i && hit(addr_i, `ADDR_SYSTEM_OPTIONS) && !options_locked_reg)
        begin
            system_options_reg <= wdata_i & `OPT_IMPL_MASK;
            options_locked_reg <= 1'b1;
        end
    end

    assign watchdog_enable_o       = system_options_reg[`OPT_WDOG_EN_BIT];
    assign watchdog_long_timeout_o = system_options_reg[`OPT_WDOG_LONG_BIT];

    // Stop gating; input is same-clock core logic
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            stop_enter_o           <= 1'b0;
            illegal_opcode_reset_o <= 1'b0;
        end
        else
        begin
            stop_enter_o <= stop_request_i & system_options_reg[`OPT_STOP_ALLOW_BIT];
            illegal_opcode_reset_o <= stop_request_i
                                    & ~system_options_reg[`OPT_STOP_ALLOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            clock_output_pin_enable_reg    <= 1'b0;
            clock_output_divide_select_reg <= '0;
        end
        else if (write_i && hit(addr_i, `ADDR_CLOCK_OUTPUT_CTRL))
        begin
            clock_output_pin_enable_reg    <= wdata_i[`CLKOUT_EN_BIT];
            clock_output_divide_select_reg <= wdata_i[`CLKOUT_DIV_HI:0];
        end
    end

    clock_output_divider u_clock_output_divider
    (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .enable_i  (clock_output_pin_enable_reg),
        .divide_i  (clock_output_divide_select_reg),
        .clk_out_o (port_c_bit2_pin_o),
        .clk_oe_o  (port_c_bit2_pin_oe_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign ack = write_i && hit(addr_i, `ADDR_WAKEUP_STATUS_CTRL) && wdata_i[`WAKE_ACK_BIT];

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wakeup_clock_select_reg     <= 1'b0;
            wakeup_interrupt_enable_reg <= 1'b0;
            wakeup_delay_select_reg     <= '0;
        end
        else if (write_i && hit(addr_i, `ADDR_WAKEUP_STATUS_CTRL))
        begin
            wakeup_clock_select_reg     <= wdata_i[`WAKE_CLKSEL_BIT];
            wakeup_interrupt_enable_reg <= wdata_i[`WAKE_IRQ_EN_BIT];
            wakeup_delay_select_reg     <= wdata_i[`WAKE_DELAY_HI:0];
        end
    end

    // Timeout beats a same-cycle acknowledge so no event is lost
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            wakeup_timeout_flag_reg <= 1'b0;
        else if (timeout)
            wakeup_timeout_flag_reg <= 1'b1;
        else if (ack)
            wakeup_timeout_flag_reg <= 1'b0;
    end

    assign periodic_wakeup_interrupt_o = wakeup_timeout_flag_reg
                                       & wakeup_interrupt_enable_reg;

    wakeup_timer u_wakeup_timer
    (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .ext_clk_i (ext_clk_i),
        .clk_sel_i (wakeup_clock_select_reg),
        .delay_i   (wakeup_delay_select_reg),
        .timeout_o (timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rdata_next = 8'h00;
        case (addr_i)
            `ADDR_SYSTEM_OPTIONS:     rdata_next = system_options_reg;
            `ADDR_CLOCK_OUTPUT_CTRL:  rdata_next = {clock_output_pin_enable_reg, 4'h0,
                                                   clock_output_divide_select_reg};
            // Reserved nibble reads a fixed value; writes never land here
            `ADDR_PART_IDENTITY_HIGH: rdata_next = {`ID_HIGH_RESERVED,
                                                   4'(`PART_ID_VALUE >> `PART_ID_HIGH_SHIFT)};
            `ADDR_PART_IDENTITY_LOW:  rdata_next = 8'(`PART_ID_VALUE);
            `ADDR_WAKEUP_STATUS_CTRL: rdata_next = {wakeup_timeout_flag_reg, 1'b0,
                                                   wakeup_clock_select_reg,
                                                   wakeup_interrupt_enable_reg, 1'b0,
                                                   wakeup_delay_select_reg};
            default:                  rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_o <= 8'h00;
        else if (read_i)
            rdata_o <= rdata_next;
        else
            rdata_o <= 8'h00;
    end
endmodule

// File: rtl/wakeup_timer.sv
// Periodic wakeup timer: free internal 1 kHz tick or divided external clock
`timescale 1ns/1ps
`include "sysconfig_defs.svh"
module wakeup_timer
(
    input  wire logic                     clk_i,       // Bus clock
    input  wire logic                     reset_i,     // Sync reset
    input  wire logic                     ext_clk_i,   // External clock pin
    input  wire logic                     clk_sel_i,   // 1 = external
    input  wire logic [`WAKE_DELAY_W-1:0] delay_i,     // Delay select
    output logic                          timeout_o    // One-cycle pulse
);
    logic [`WAKE_CNT_W-1:0] tick_cnt_reg;
    logic                   int_tick;
    logic [2:0]             ext_sync_reg;
    logic                   ext_tick;
    logic                   tick;
    logic [15:0]            period_cnt_reg;
    logic [15:0]            period;

    function automatic logic [15:0] period_of(input logic ext, input logic [2:0] sel);
        logic [15:0] p;
        p = 16'h0000;
        if (ext)
        begin
            case (sel)
                3'h1: p = `WAKE_EXT_EDGES_1;
                3'h2: p = `WAKE_EXT_EDGES_2;
                3'h3: p = `WAKE_EXT_EDGES_3;
                3'h4: p = `WAKE_EXT_EDGES_4;
                3'h5: p = `WAKE_EXT_EDGES_5;
                3'h6: p = `WAKE_EXT_EDGES_6;
                3'h7: p = `WAKE_EXT_EDGES_7;
                default: p = 16'h0000;
            endcase
        end
        else
        begin
            case (sel)
                3'h1: p = `WAKE_INT_TICKS_1;
                3'h2: p = `WAKE_INT_TICKS_2;
                3'h3: p = `WAKE_INT_TICKS_3;
                3'h4: p = `WAKE_INT_TICKS_4;
                3'h5: p = `WAKE_INT_TICKS_5;
                3'h6: p = `WAKE_INT_TICKS_6;
                3'h7: p = `WAKE_INT_TICKS_7;
                default: p = 16'h0000;
            endcase
        end
        return p;
    endfunction

    // Internal tick never stops, whatever else is configured
    always_ff @(posedge clk_i)
    begin
        if (reset_i || tick_cnt_reg == `WAKE_CNT_W'(`INT_TICK_CYCLES - 1))
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
    assign int_tick = (tick_cnt_reg == `WAKE_CNT_W'(`INT_TICK_CYCLES - 1));

    // Pin passes two flops before the edge detector
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ext_sync_reg <= 3'h0;
        else
            ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
    end
    assign ext_tick = ext_sync_reg[1] & ~ext_sync_reg[2];

    assign tick   = clk_sel_i ? ext_tick : int_tick;
    assign period = period_of(clk_sel_i, delay_i);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || period == 16'h0000)
        begin
            period_cnt_reg <= '0;
            timeout_o      <= 1'b0;
        end
        else if (tick && period_cnt_reg >= period - 16'h0001)
        begin
            period_cnt_reg <= '0;
            timeout_o      <= 1'b1;
        end
        else
        begin
            if (tick)
                period_cnt_reg <= period_cnt_reg + 16'h0001;
            timeout_o <= 1'b0;
        end
    end
endmodule

// File: verif/sysconfig_asserts.sv
// Port-level assertions for the system configuration block
`timescale 1ns/1ps
`include "sysconfig_defs.svh"
module sysconfig_asserts
(
    input wire logic       clk_i,                   // Bus clock
    input wire logic       reset_i,                 // Sync reset
    input wire logic [3:0] addr_i,                  // Address
    input wire logic [7:0] wdata_i,                 // Write data
    input wire logic       write_i,                 // Write strobe
    input wire logic       read_i,                  // Read strobe
    input wire logic [7:0] rdata_o,                 // Read data
    input wire logic       stop_request_i,          // Stop executed
    input wire logic       stop_enter_o,            // Stop pulse
    input wire logic       illegal_opcode_reset_o,  // Reset pulse
    input wire logic       watchdog_enable_o,       // Watchdog on
    input wire logic       watchdog_long_timeout_o, // Long period
    input wire logic       port_c_bit2_pin_o,       // Pin level
    input wire logic       port_c_bit2_pin_oe_o     // Pin enable
);
    logic [7:0] opt_sh;
    logic       opt_lock;
    logic       en_sh;
    logic [2:0] div_sh;
    ////////////////////////////////////////////////////////////////
    // Shadow copies rebuilt from bus traffic only
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            opt_sh   <= `OPT_RESET_VALUE;
            opt_lock <= 1'b0;
            en_sh    <= 1'b0;
            div_sh   <= 3'h0;
        end
        else if (write_i)
        begin
            if (addr_i == `ADDR_SYSTEM_OPTIONS && !opt_lock)
            begin
                opt_sh   <= wdata_i & `OPT_IMPL_MASK;
                opt_lock <= 1'b1;
            end
            if (addr_i == `ADDR_CLOCK_OUTPUT_CTRL)
            begin
                en_sh  <= wdata_i[7];
                div_sh <= wdata_i[2:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_wdog_enable_level: assert property (watchdog_enable_o == opt_sh[7])
        else $error("watchdog enable differs from options");
    a_wdog_long_level: assert property (watchdog_long_timeout_o == opt_sh[6])
        else $error("watchdog period differs from options");
    a_stop_decision: assert property (stop_request_i |=>
        stop_enter_o == $past(opt_sh[5]) && illegal_opcode_reset_o != $past(opt_sh[5]))
        else $error("wrong stop outcome");
    a_no_spurious_stop: assert property (!$past(stop_request_i) |->
        !stop_enter_o && !illegal_opcode_reset_o)
        else $error("stop output without request");
    a_options_readback: assert property (read_i && addr_i == `ADDR_SYSTEM_OPTIONS |=>
        rdata_o == $past(opt_sh))
        else $error("options read wrong");
    a_id_high_nibble: assert property (read_i && addr_i == `ADDR_PART_IDENTITY_HIGH |=>
        rdata_o[3:0] == 4'(`PART_ID_VALUE >> 8))
        else $error("identity high wrong");
    a_id_low_byte: assert property (read_i && addr_i == `ADDR_PART_IDENTITY_LOW |=>
        rdata_o == 8'(`PART_ID_VALUE))
        else $error("identity low wrong");
    a_oe_follows_enable: assert property (port_c_bit2_pin_oe_o == $past(en_sh))
        else $error("pin enable not one cycle behind");
    a_pin_low_div0: assert property ($past(div_sh) == 3'h0 && div_sh == 3'h0 |->
        !port_c_bit2_pin_o)
        else $error("pin not low with zero divide");
endmodule
bind system_config_and_periodic_wakeup sysconfig_asserts chk
(
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .stop_request_i(stop_request_i),
    .stop_enter_o(stop_enter_o), .illegal_opcode_reset_o(illegal_opcode_reset_o),
    .watchdog_enable_o(watchdog_enable_o), .watchdog_long_timeout_o(watchdog_long_timeout_o),
    .port_c_bit2_pin_o(port_c_bit2_pin_o), .port_c_bit2_pin_oe_o(port_c_bit2_pin_oe_o)
);

// File: verif/system_config_and_periodic_wakeup_tb_top.sv
// Self-checking bench for the system configuration block
`timescale 1ns/1ps
`include "sysconfig_defs.svh"
module system_config_and_periodic_wakeup_tb_top;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       write_i = 1'b0;
    logic       read_i = 1'b0;
    logic       ext_clk_i = 1'b0;
    logic       stop_request_i = 1'b0;
    logic [7:0] rdata_o;
    logic       stop_o, ilop_o, wden_o, wdlong_o, pin_o, pin_oe_o, irq_o;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         seed = 98930;
    int         model [16];
    logic [7:0] v;
    int         n;
    system_config_and_periodic_wakeup dut
    (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk_i),
        .stop_request_i(stop_request_i), .stop_enter_o(stop_o), .illegal_opcode_reset_o(ilop_o),
        .watchdog_enable_o(wden_o), .watchdog_long_timeout_o(wdlong_o),
        .port_c_bit2_pin_o(pin_o), .port_c_bit2_pin_oe_o(pin_oe_o),
        .periodic_wakeup_interrupt_o(irq_o)
    );
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd_chk(logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1;
        chk("rdata", 8'(model[a]), rdata_o);
    endtask
    task automatic stop_chk(logic allow);
        @(posedge clk_i);
        stop_request_i <= 1'b1;
        @(posedge clk_i);
        stop_request_i <= 1'b0;
        #1;
        chk("stop_enter", {7'h0, allow}, {7'h0, stop_o});
        chk("illegal_reset", {7'h0, !allow}, {7'h0, ilop_o});
    endtask
    // Slow enough that the two-flop sync never merges edges
    task automatic ext_edges(int k);
        repeat (k)
        begin
            @(posedge clk_i);
            ext_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clk_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task automatic half_chk(logic [7:0] d);
        logic p;
        int   c;
        repeat (3) @(posedge clk_i);
        #1;
        p = pin_o;
        for (c = 0; c < 40 && pin_o === p; c++)
        begin
            @(posedge clk_i);
            #1;
        end
        p = pin_o;
        for (c = 0; c < 40 && pin_o === p; c++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk("half_period", d, 8'(c));
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        model = '{default: 0};
        model[`ADDR_SYSTEM_OPTIONS] = `OPT_RESET_VALUE;
        model[`ADDR_PART_IDENTITY_HIGH] = `PART_ID_VALUE >> 8;
        model[`ADDR_PART_IDENTITY_LOW] = `PART_ID_VALUE & 12'h0FF;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        for (n = 0; n < 16; n++) rd_chk(4'(n));
        chk("wdog", 8'h03, {6'h0, wden_o, wdlong_o});
        stop_chk(1'b0);
        v = 8'($random(seed));
        wr(`ADDR_PART_IDENTITY_HIGH, v);
        wr(`ADDR_PART_IDENTITY_LOW, ~v);
        rd_chk(`ADDR_PART_IDENTITY_HIGH);
        rd_chk(`ADDR_PART_IDENTITY_LOW);
        v = 8'($random(seed)) | 8'h20;
        wr(`ADDR_SYSTEM_OPTIONS, v);
        model[`ADDR_SYSTEM_OPTIONS] = v & `OPT_IMPL_MASK;
        wr(`ADDR_SYSTEM_OPTIONS, ~v);
        rd_chk(`ADDR_SYSTEM_OPTIONS);
        chk("wdog", {6'h0, v[7:6]}, {6'h0, wden_o, wdlong_o});
        stop_chk(1'b1);
        for (n = 1; n < 8; n++)
        begin
            wr(`ADDR_CLOCK_OUTPUT_CTRL, 8'h80 | 8'(n));
            model[`ADDR_CLOCK_OUTPUT_CTRL] = 8'h80 | n;
            rd_chk(`ADDR_CLOCK_OUTPUT_CTRL);
            half_chk(8'(n));
        end
        wr(`ADDR_CLOCK_OUTPUT_CTRL, 8'h80);
        repeat (3) @(posedge clk_i);
        #1;
        chk("pin_div0", 8'h02, {6'h0, pin_oe_o, pin_o});
        wr(`ADDR_CLOCK_OUTPUT_CTRL, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
        chk("pin_off", 8'h00, {7'h0, pin_oe_o});
        // External source, shortest divide, interrupt enabled
        wr(`ADDR_WAKEUP_STATUS_CTRL, 8'h31);
        model[`ADDR_WAKEUP_STATUS_CTRL] = 8'h31;
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        ext_edges(255);
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        chk("irq", 8'h00, {7'h0, irq_o});
        ext_edges(1);
        model[`ADDR_WAKEUP_STATUS_CTRL] = 8'hB1;
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        chk("irq", 8'h01, {7'h0, irq_o});
        wr(`ADDR_WAKEUP_STATUS_CTRL, 8'h31);
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        wr(`ADDR_WAKEUP_STATUS_CTRL, 8'h71);
        model[`ADDR_WAKEUP_STATUS_CTRL] = 8'h31;
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        chk("irq", 8'h00, {7'h0, irq_o});
        wr(`ADDR_WAKEUP_STATUS_CTRL, 8'h21);
        ext_edges(256);
        model[`ADDR_WAKEUP_STATUS_CTRL] = 8'hA1;
        rd_chk(`ADDR_WAKEUP_STATUS_CTRL);
        chk("irq", 8'h00, {7'h0, irq_o});
        tally_and_finish();
    end
endmodule
